/* File: hdl/system_guard_timer.sv */
// Purpose: system guard timer with control and feed registers on APB
// Assumes: APB master as usual, one clock, async active-low reset
// Notes: timeout resets the system through SYS_RESET pulse
`timescale 1ns/1ps
module system_guard_timer
  import guard_pkg::*;
#(
  parameter longint UNIT_CYC = MS250_CYC
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic SYS_RESET,
  output logic [2:0] TIMEOUT_CODE
);

  guard_state_t cur, next_cur;
  logic access;
  logic hit_ctrl;
  logic hit_feed;
  logic feed;
  logic [35:0] period;

  ////////////////////////////////////////////////////////////////
  // period lookup in multiples of 250 ms
  always_comb begin
    case (cur.code)
      3'h1: period = 36'(UNIT_CYC);
      3'h2: period = 36'(UNIT_CYC * 2);
      3'h3: period = 36'(UNIT_CYC * 4);
      3'h5: period = 36'(UNIT_CYC * 8);
      3'h6: period = 36'(UNIT_CYC * 16);
      3'h7: period = 36'(UNIT_CYC * 32);
      default: period = '0;
    endcase
  end

  assign access = PSEL && PENABLE && !cur.pready;
  assign hit_ctrl = PADDR == CTRL_ADDR;
  assign hit_feed = PADDR == FEED_ADDR;
  assign feed = access && PWRITE && hit_feed && PWDATA[7:0] == FEED_KEY;

  ////////////////////////////////////////////////////////////////
  always_comb begin
    next_cur = cur;
    next_cur.pready = access;
    next_cur.pslverr = access && !(hit_ctrl || (hit_feed && PWRITE));
    next_cur.prdata = '0;
    if (access && !PWRITE && hit_ctrl) begin
      next_cur.prdata = {29'h0000_000, cur.code};
    end
    // window closes after its count runs out
    if (cur.win_open) begin
      if (cur.win_cnt == 13'(WINDOW_CYC - 1)) begin
        next_cur.win_open = 1'b0;
      end else begin
        next_cur.win_cnt = cur.win_cnt + 13'h0001;
      end
    end
    if (access && PWRITE && hit_ctrl && cur.win_open) begin
      next_cur.code = PWDATA[CODE_LSB +: CODE_W];
      next_cur.win_open = 1'b0;
      next_cur.count = '0;
    end
    if (cur.code != CODE_OFF && cur.code != CODE_RSVD) begin
      if (cur.count >= period - 36'h1) begin
        next_cur.count = '0;
        next_cur.sys_rst = 1'b1;
        next_cur.rst_cnt = 5'(RST_PULSE_CYC);
      end else begin
        next_cur.count = cur.count + 36'h1;
      end
    end else begin
      next_cur.count = '0;
    end
    if (feed) begin
      next_cur.count = '0;
      next_cur.win_open = 1'b1;
      next_cur.win_cnt = '0;
    end
    if (cur.sys_rst) begin
      // the system reset also returns the timer to its reset state
      next_cur.code = CODE_RESET;
      next_cur.count = '0;
      next_cur.win_open = 1'b0;
      next_cur.win_cnt = '0;
      if (cur.rst_cnt == 5'h01) begin
        next_cur.sys_rst = 1'b0;
      end
      next_cur.rst_cnt = cur.rst_cnt - 5'h01;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cur <= '0;
    end else if (CE) begin
      cur <= next_cur;
    end
  end

  assign PRDATA = cur.prdata;
  assign PREADY = cur.pready;
  assign PSLVERR = cur.pslverr;
  assign SYS_RESET = cur.sys_rst;
  assign TIMEOUT_CODE = cur.code;

  ////////////////////////////////////////////////////////////////
  AST_LATE_CTRL_IGNORED: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && access && PWRITE && hit_ctrl && !cur.win_open && !cur.sys_rst)
      |=> $stable(cur.code))
    else $error("control write outside window changed code");
  AST_CTRL_IN_WINDOW: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && access && PWRITE && hit_ctrl && cur.win_open && !cur.sys_rst)
      |=> cur.code == $past(PWDATA[2:0]))
    else $error("control write in window not taken");
  AST_FEED_CLEARS: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && feed && !cur.sys_rst) |=> (cur.count == 36'h0 && cur.win_open))
    else $error("feed did not clear counter");
  AST_OFF_NO_COUNT: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && cur.code == CODE_OFF) |=> cur.count == 36'h0)
    else $error("counter ran while disabled");
  AST_TIMEOUT_RESET: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && cur.code == 3'h1 && cur.count == 36'(UNIT_CYC - 1) && !feed && !cur.sys_rst)
      |=> SYS_RESET)
    else $error("timeout did not reset system");
  AST_COUNT_STEP: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && cur.code == 3'h3 && !feed && !cur.sys_rst && cur.count < 36'h10 && !access)
      |=> cur.count == $past(cur.count) + 36'h1)
    else $error("counter did not advance");
  AST_RESET_CLEARS: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && cur.sys_rst && cur.rst_cnt == 5'h01) |=> (!SYS_RESET && TIMEOUT_CODE == 3'h0))
    else $error("system reset did not return code to off");
  AST_APB_ONE_WAIT: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && PSEL && PENABLE && !PREADY) |=> PREADY)
    else $error("apb answer late");
endmodule // system_guard_timer

/* File: pkg/guard_pkg.sv */
// Purpose: shared constants and types for the system guard timer
// Assumes: 200 MHz clock, APB with 32-bit data
// Notes: control code sits in bits 2:0 and the feed key in the low byte of each word
package guard_pkg;
  localparam logic [31:0] CTRL_ADDR = 32'h2380_0000;
  localparam logic [31:0] FEED_ADDR = 32'h23c0_0000;
  localparam logic [7:0] FEED_KEY = 8'h05;
  localparam logic [2:0] CODE_RESET = 3'h0;
  localparam logic [2:0] CODE_OFF = 3'h0;
  localparam logic [2:0] CODE_RSVD = 3'h4;
  localparam int CLK_MHZ = 200;
  localparam int WINDOW_US = 30;
  // longest time rounds down
  localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
  localparam int MS250_CYC = 250 * 1000 * CLK_MHZ;
  localparam int RST_PULSE_CYC = 16;
  localparam int CODE_LSB = 0;
  localparam int CODE_W = 3;

  typedef struct packed {
    logic [2:0] code;
    logic [35:0] count;
    logic [12:0] win_cnt;
    logic win_open;
    logic [4:0] rst_cnt;
    logic sys_rst;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } guard_state_t;
endpackage

/* File: test/test_system_guard_timer.sv */
// Purpose: self-checking bench for the system guard timer
// Assumes: UNIT_CYC shortened to 20 cycles, CE held high
// Notes: registers reached through an APB master task
`timescale 1ns/1ps
module test_system_guard_timer;
  import guard_pkg::*;
  logic CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [31:0] PADDR = '0, PWDATA = '0, PRDATA, rd;
  logic PREADY, PSLVERR, SYS_RESET, err;
  logic [2:0] TIMEOUT_CODE;
  int mismatches = 0, n_tests = 0, k, p;
  always #2.5 CLK = ~CLK;
  system_guard_timer #(.UNIT_CYC(20)) DUT (.CLK(CLK), .RSTN(RSTN), .CE(1'b1), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SYS_RESET(SYS_RESET), .TIMEOUT_CODE(TIMEOUT_CODE));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic [31:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1;
    PADDR <= a;
    PWRITE <= w;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    rd = PRDATA;
    err = PSLVERR;
    if (n == 50) mismatches++;
    PSEL <= 0;
    PENABLE <= 0;
    @(posedge CLK);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_lock;
    check(TIMEOUT_CODE, CODE_RESET);
    apb(CTRL_ADDR, 1, 3);
    check(TIMEOUT_CODE, CODE_OFF);
    apb(FEED_ADDR, 0, 0);
    check(err, 1);
    apb(FEED_ADDR, 1, 6);
    apb(CTRL_ADDR, 1, 3);
    check(TIMEOUT_CODE, CODE_OFF);
    apb(FEED_ADDR, 1, FEED_KEY);
    repeat (6010) @(posedge CLK);
    apb(CTRL_ADDR, 1, 3);
    check(TIMEOUT_CODE, CODE_OFF);
  endtask
  task t_feed;
    apb(FEED_ADDR, 1, FEED_KEY);
    apb(CTRL_ADDR, 1, 2);
    apb(CTRL_ADDR, 0, 0);
    check(rd, 2);
    check(err, 0);
    k = 0;
    repeat (6) begin
      repeat (20) begin
        @(posedge CLK);
        if (SYS_RESET !== 1'b0) k++;
      end
      apb(FEED_ADDR, 1, FEED_KEY);
    end
    check(k, 0);
  endtask
  // each of codes 1 to 7 times out after its own period, except code 4, which never does
  task t_codes;
    for (int c = 1; c < 8; c++) begin
      p = (c == 4) ? 900 : 20 << (c - 1 - (c > 4));
      apb(FEED_ADDR, 1, FEED_KEY);
      apb(CTRL_ADDR, 1, c);
      check(TIMEOUT_CODE, c);
      k = 0;
      while (SYS_RESET !== 1'b1 && k < 800) begin
        @(posedge CLK);
        k++;
      end
      check(k >= p - 8 && k <= p + 2 || c == 4 && k == 800, 1);
      repeat (20) @(posedge CLK);
      check(TIMEOUT_CODE, (c == 4) ? 4 : 0);
      if (c == 4) apb(FEED_ADDR, 1, FEED_KEY);
      if (c == 4) apb(CTRL_ADDR, 1, 0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge CLK);
    RSTN <= 1;
    @(posedge CLK);
    t_lock;
    t_feed;
    t_codes;
    summarize;
  end
  initial begin
    #100000;
    mismatches++;
    summarize;
  end
endmodule // test_system_guard_timer
